// ===== core/llm_pkg.sv
// Package of constants for the line loss and lock monitor
package llm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] LLM_TLIC_ADDR   = 16'h0383;
  localparam logic [15:0] LLM_STATUS_ADDR = 16'h0384;
  localparam logic [7:0]  LLM_TLIC_RESET  = 8'h00;

  // Control register field positions
  localparam int LLM_SYN_EN_BIT  = 0;
  localparam int LLM_SYN_SRC_BIT = 1;
  localparam int LLM_REF_SEL_LO  = 2;
  localparam int LLM_OUT_SEL_LO  = 4;
  localparam int LLM_PORT_BIT    = 6;

  // Status register field positions
  localparam int LLM_ST_LOC_BIT  = 0;
  localparam int LLM_ST_LOP_BIT  = 1;
  localparam int LLM_ST_LOCK_BIT = 2;
  localparam int LLM_ST_LOL_BIT  = 3;

  // Reference frequency choices, in kHz
  localparam int LLM_REF_KHZ_0 = 19440;
  localparam int LLM_REF_KHZ_1 = 38880;
  localparam int LLM_REF_KHZ_2 = 51840;
  localparam int LLM_REF_KHZ_3 = 77760;

  // Synthesizer output choices
  typedef enum logic [1:0] {
    LLM_OUT_155 = 2'h0,
    LLM_OUT_19  = 2'h1,
    LLM_OUT_77  = 2'h2
  } llm_out_e;

  // Lock tolerance: 0.05 percent is 1 part in 2000
  localparam int LLM_PPM_TOL     = 500;
  localparam int LLM_WIN_CYCLES  = 4096;

endpackage

// ===== core/llm_sync.sv
// Two-stage synchroniser for a vector of level inputs
`timescale 1ns/1ps
module llm_sync
  import llm_pkg::*;
#(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  // Stage one feeds stage two only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// ===== core/llm_monitor.sv
// Line loss, loss of interface and lock monitor with synthesizer control
`timescale 1ns/1ps

// Function
// RULE1 - With the synthesizer enabled the board supplies a 19.44, 38.88, 51.84 or 77.76 MHz reference.
// RULE2 - An enabled, configured synthesizer yields a 155.52, 19.44 or 77.76 MHz line clock and is its source.
// RULE3 - Software writes the control register at 0x0383 to pick the reference and make the synthesizer the source.
// RULE4 - With the synthesizer off the board supplies exactly 19.44 MHz and no line clocks are made.
// RULE5 - Loss of optical carrier is declared when carrier-loss and matching interface-loss inputs are equal.
// RULE6 - Loss of interface is declared while the active port's interface-loss input is high.
// RULE7 - Only the active port's loss inputs count; the other port's are ignored.
// RULE8 - The lock indicator is high while the recovery oscillator is within 0.05 percent of the reference.
// RULE9 - Beyond 0.05 percent the lock indicator is low and loss of lock is declared.
// RULE10 - Loss inputs are synchronised first and each condition is a readable status flag.
module llm_monitor
  import llm_pkg::*;
#(
  parameter int WIN_CYCLES = LLM_WIN_CYCLES,
  parameter int CNT_W      = 24
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              carrier_loss_in_main,
  input  wire logic              carrier_loss_in_backup,
  input  wire logic              diff_loss_in_main,
  input  wire logic              diff_loss_in_backup,
  input  wire logic [CNT_W-1:0]  ref_edge_count,
  input  wire logic [CNT_W-1:0]  vco_edge_count,
  input  wire logic              count_valid,
  output logic                   recovery_lock_indicator,
  output logic                   loss_of_carrier,
  output logic                   loss_of_interface,
  output logic                   synth_enable,
  output logic                   synth_is_source,
  output logic      [1:0]        synth_ref_sel,
  output logic      [1:0]        synth_out_sel,
  output logic                   line_clock_on
);

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [7:0] tlic_r;
  logic [7:0] tlic_nxt;

  // Address matches for the two mapped locations
  wire        tlic_hit    = (reg_addr == LLM_TLIC_ADDR);
  wire        status_hit  = (reg_addr == LLM_STATUS_ADDR);

  // Qualified strobes; unmapped writes fall through unused
  wire        tlic_we     = reg_wr & tlic_hit;               // see RULE3
  wire        tlic_re     = reg_rd & tlic_hit;
  wire        status_re   = reg_rd & status_hit;

  // Next control word: a write replaces the whole byte
  assign tlic_nxt = tlic_we ? reg_wdata : tlic_r;            // see RULE3

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  // Control word, cleared by reset so the synthesizer starts off
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tlic_r <= LLM_TLIC_RESET;
    end else begin
      tlic_r <= tlic_nxt;
    end
  end

  // Raw fields of the control word
  wire        fld_syn_en  = tlic_r[LLM_SYN_EN_BIT];
  wire        fld_syn_src = tlic_r[LLM_SYN_SRC_BIT];
  wire [1:0]  fld_ref_sel = tlic_r[LLM_REF_SEL_LO +: 2];
  wire [1:0]  fld_out_sel = tlic_r[LLM_OUT_SEL_LO +: 2];
  wire        port_backup = tlic_r[LLM_PORT_BIT];            // see RULE7

  // ----------------------------------------------------------------
  // Synthesizer steering
  // ----------------------------------------------------------------
  localparam logic [1:0] OUT_OFF = 2'h3;

  // Source only when enabled; a disabled synthesizer cannot drive the line
  wire        src_ok      = fld_syn_en & fld_syn_src;        // see RULE2
  // Output choice code 3 is unused and means no line clock
  wire        out_valid   = (fld_out_sel != OUT_OFF);

  // Decoded steering outputs
  assign synth_enable    = fld_syn_en;
  assign synth_is_source = src_ok;                           // see RULE2
  assign synth_ref_sel   = fld_syn_en ? fld_ref_sel : 2'h0;  // see RULE1 see RULE4
  assign synth_out_sel   = fld_out_sel;
  assign line_clock_on   = src_ok & out_valid;               // see RULE2 see RULE4

  // ----------------------------------------------------------------
  // Loss input conditioning
  // ----------------------------------------------------------------
  localparam int PAIRS = 2;

  logic [3:0]       loss_sync;
  logic [PAIRS-1:0] main_pair;
  logic [PAIRS-1:0] backup_pair;
  logic [PAIRS-1:0] act_pair;

  // Pin bundle, backup pair above main pair
  wire [3:0] loss_pins = {diff_loss_in_backup, carrier_loss_in_backup,
                          diff_loss_in_main, carrier_loss_in_main};

  // Pins are free running levels; two stages before any decode
  llm_sync #(
    .WIDTH (4)
  ) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in (loss_pins),                                     // see RULE10
    .sync_out (loss_sync)
  );

  // Split the synchronised bus into the two port pairs
  assign main_pair   = loss_sync[1:0];
  assign backup_pair = loss_sync[3:2];

  // Per member: take the active port, the other port is ignored
  for (genvar p = 0; p < PAIRS; p++) begin : g_act
    assign act_pair[p] = port_backup ? backup_pair[p] : main_pair[p]; // see RULE7
  end

  // Member 0 is carrier loss, member 1 interface loss
  wire act_carrier = act_pair[0];
  wire act_diff    = act_pair[1];
  wire loc_nxt     = ~(act_carrier ^ act_diff);                 // see RULE5
  wire lop_nxt     = act_diff;                                  // see RULE6

  // Carrier loss flag, a live level with no clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      loss_of_carrier   <= 1'b0;
    end else begin
      loss_of_carrier   <= loc_nxt;                            // see RULE5
    end
  end

  // Interface loss flag, a live level with no clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      loss_of_interface <= 1'b0;
    end else begin
      loss_of_interface <= lop_nxt;                            // see RULE6
    end
  end

  // ----------------------------------------------------------------
  // Lock detection
  // ----------------------------------------------------------------
  // Counts come from edge counters over a common window outside
  // this block; difference within ref/2000 means lock.
  // Tolerance divisor: one million over the parts-per-million limit
  localparam int TOL_DIV = 1000000 / LLM_PPM_TOL;

  logic [CNT_W-1:0] big_w;
  logic [CNT_W-1:0] small_w;
  logic [CNT_W-1:0] diff_w;
  logic [CNT_W-1:0] tol_w;

  // Order the two counts so the difference never wraps
  wire              vco_fast = (vco_edge_count > ref_edge_count);
  assign big_w   = vco_fast ? vco_edge_count : ref_edge_count;
  assign small_w = vco_fast ? ref_edge_count : vco_edge_count;
  assign diff_w  = big_w - small_w;
  // Allowed spread scales with the reference count
  assign tol_w   = CNT_W'(ref_edge_count / CNT_W'(TOL_DIV));

  // Verdict of the current comparison, held between comparisons
  wire within_tol = (diff_w <= tol_w);                                  // see RULE8
  wire lock_nxt   = count_valid ? within_tol : recovery_lock_indicator; // see RULE8 see RULE9

  // Lock indicator follows each completed comparison
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      recovery_lock_indicator <= 1'b0;
    end else begin
      recovery_lock_indicator <= lock_nxt;                     // see RULE8 see RULE9
    end
  end

  // Loss of lock is the inverse of the indicator
  wire loss_of_lock = ~recovery_lock_indicator;                // see RULE9

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  logic [7:0] status_w;
  logic [7:0] rd_nxt;

  // Each live condition on its own bit, unused bits read zero
  always_comb begin
    status_w                  = 8'h00;
    status_w[LLM_ST_LOC_BIT]  = loss_of_carrier;               // see RULE10
    status_w[LLM_ST_LOP_BIT]  = loss_of_interface;             // see RULE10
    status_w[LLM_ST_LOCK_BIT] = recovery_lock_indicator;       // see RULE8
    status_w[LLM_ST_LOL_BIT]  = loss_of_lock;                  // see RULE9
  end

  // Read selection; unmapped addresses return zero
  assign rd_nxt = tlic_re   ? tlic_r   :
                  status_re ? status_w : 8'h00;

  // Read data held from a flip-flop
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end
  end

endmodule

// ===== test/llm_monitor_assertions.sv
// Checker for the monitor ports
`timescale 1ns/1ps
module llm_chk
  import llm_pkg::*;
#(parameter int CNT_W = 24) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  input  wire logic             count_valid,
  input  wire logic             recovery_lock_indicator,
  input  wire logic             line_clock_on,
  input  wire logic             carrier_loss_in_main,
  input  wire logic             carrier_loss_in_backup,
  input  wire logic             diff_loss_in_main,
  input  wire logic             diff_loss_in_backup,
  input  wire logic             loss_of_carrier,
  input  wire logic             loss_of_interface,
  input  wire logic             synth_enable,
  input  wire logic [15:0]      reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic [7:0]       reg_rdata,
  input  wire logic [CNT_W-1:0] ref_edge_count,
  input  wire logic [CNT_W-1:0] vco_edge_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic port_r;
  wire tw = reg_wr && reg_addr == LLM_TLIC_ADDR;
  wire [4:0] q = {port_r, carrier_loss_in_main, carrier_loss_in_backup, diff_loss_in_main, diff_loss_in_backup};
  wire c = port_r ? q[2] : q[3];
  wire d = port_r ? q[0] : q[1];
  wire [CNT_W-1:0] lo = vco_edge_count < ref_edge_count ? vco_edge_count : ref_edge_count;
  wire near = (vco_edge_count ^ ref_edge_count ^ lo) - lo <= ref_edge_count / 2000;
  // Copy of the active port select
  always_ff @(posedge sys_clk)
    if (sys_rst) port_r <= 1'b0;
    else if (tw) port_r <= reg_wdata[LLM_PORT_BIT];
  carrier_loss_a: assert property ($stable(q)[*5] |-> loss_of_carrier == (c == d)) else $error("bad carrier");
  iface_loss_a: assert property ($stable(q)[*5] |-> loss_of_interface == d) else $error("bad interface");
  lock_follow_a: assert property (count_valid |=> recovery_lock_indicator == $past(near))
    else $error("bad lock");
  lock_hold_a: assert property (!count_valid |=> $stable(recovery_lock_indicator)) else $error("lock moved");
  status_lock_a: assert property (reg_rd && reg_addr == LLM_STATUS_ADDR |=> reg_rdata[2] == $past(recovery_lock_indicator))
    else $error("bad status");
  config_write_a: assert property (tw |=> synth_enable == $past(reg_wdata[0])) else $error("bad config");
  clk_off_a: assert property (!synth_enable |-> !line_clock_on) else $error("clock while off");
  cover property (count_valid ##1 recovery_lock_indicator);
  cover property (loss_of_carrier && port_r);
  cover property (tw ##1 line_clock_on);
endmodule
bind llm_monitor llm_chk #(.CNT_W(CNT_W)) chk_u (.*);

// ===== test/llm_optic_model.sv
// Transceiver and reference oscillator model
`timescale 1ns/1ps
module llm_optic_model (
  input  wire logic   sys_clk,
  output logic        carrier_loss_in_main,
  output logic        carrier_loss_in_backup,
  output logic        diff_loss_in_main,
  output logic        diff_loss_in_backup,
  output logic        count_valid = 1'b0,
  output logic [23:0] ref_edge_count = 24'h0,
  output logic [23:0] vco_edge_count = 24'h0
);
  // Notional window, long enough that 0.05 percent spans hundreds of counts
  localparam longint WIN_CYC = 1048576;
  int ref_khz = 19440, ppm = 0;
  logic [3:0] loss = 4'h0;
  logic [5:0] tick = 6'h00;
  assign {carrier_loss_in_main, carrier_loss_in_backup, diff_loss_in_main, diff_loss_in_backup} = loss;
  // Counts of the notional window, given every 64 cycles
  always @(posedge sys_clk) begin
    tick <= tick + 6'h01;
    count_valid <= &tick;
    ref_edge_count <= 24'(longint'(ref_khz) * WIN_CYC / 64'sd20000);
    vco_edge_count <= 24'(longint'(ref_khz) * WIN_CYC * longint'(1000000 + ppm) / 64'sd20000000000);
  end
endmodule

// ===== test/llm_monitor_tb_top.sv
// Testbench of the line loss and lock monitor
`timescale 1ns/1ps
module llm_monitor_tb_top;
  import llm_pkg::*;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic carrier_loss_in_main, carrier_loss_in_backup, diff_loss_in_main, diff_loss_in_backup, count_valid;
  logic recovery_lock_indicator, loss_of_carrier, loss_of_interface, synth_enable, synth_is_source, line_clock_on;
  logic [1:0] synth_ref_sel, synth_out_sel;
  logic [23:0] ref_edge_count, vco_edge_count;
  int err_count = 0, samples_checked = 0, cyc = 0;
  int refs[4] = '{LLM_REF_KHZ_0, LLM_REF_KHZ_1, LLM_REF_KHZ_2, LLM_REF_KHZ_3};
  always #25 sys_clk = ~sys_clk;
  llm_optic_model part_u (.*);
  llm_monitor dut_u (.*);
  task automatic chk(input logic [7:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task automatic t_regs;
    bus(0, LLM_TLIC_ADDR, 0);
    chk(reg_rdata, LLM_TLIC_RESET);
    bus(0, 16'h0385, 0);
    chk(reg_rdata, 8'h00);
    for (int i = 0; i < 4; i++) begin
      bus(1, LLM_TLIC_ADDR, 8'(i * 20 + 3));
      chk({synth_out_sel, synth_ref_sel, line_clock_on, 1'b0, synth_is_source, synth_enable}, {2'(i), 2'(i), i != 3, 3'h3});
      bus(0, LLM_TLIC_ADDR, 0);
      chk(reg_rdata, 8'(i * 20 + 3));
    end
    bus(1, LLM_TLIC_ADDR, 8'h0e);
    chk({4'h0, synth_ref_sel, line_clock_on, synth_is_source}, 8'h00);
    $display("registers done");
  endtask
  task automatic t_loss;
    logic c, d;
    for (int i = 0; i < 32; i++) begin
      bus(1, LLM_TLIC_ADDR, i[4] ? 8'h40 : 8'h00);
      part_u.loss <= i[3:0];
      repeat (4) @(posedge sys_clk);
      c = i[4] ? i[2] : i[3];
      d = i[4] ? i[0] : i[1];
      chk({6'h0, loss_of_interface, loss_of_carrier}, {6'h0, d, c == d});
      bus(0, LLM_STATUS_ADDR, 0);
      chk({6'h0, reg_rdata[1:0]}, {6'h0, d, c == d});
    end
    $display("loss done");
  endtask
  task automatic t_lock(input int p, input logic e);
    part_u.ppm <= p;
    repeat (130) @(posedge sys_clk);
    chk({7'h0, recovery_lock_indicator}, {7'h0, e});
    bus(0, LLM_STATUS_ADDR, 0);
    chk({4'h0, reg_rdata[3:2], 2'h0}, {4'h0, !e, e, 2'h0});
  endtask
  task automatic t_lock_refs;
    for (int k = 0; k < 4; k++) begin
      bus(1, LLM_TLIC_ADDR, 8'(k * 4 + 3));
      part_u.ref_khz <= refs[k];
      t_lock(400, 1);
      t_lock(-600, 0);
    end
    $display("lock done");
  endtask
  task automatic results;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      results;
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_regs;
    t_loss;
    t_lock_refs;
    results;
  end
endmodule
